//--- cmo_pkg.sv
// Shared constants and types of the processor-core memory organisation block.
// Assumes one 20 MHz clock and a synchronous active-high reset in every user.
package cmo_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Address spaces
    localparam int CMO_CODE_ONCHIP_BYTES = 4096;
    localparam int CMO_CODE_OFFCHIP_BYTES = 61440;
    localparam int CMO_XDATA_BYTES = 65536;
    localparam int CMO_IRAM_BYTES = 128;
    localparam int CMO_SFR_USED = 20;
    localparam logic [15:0] CMO_CODE_ONCHIP_TOP = 16'h0FFF;
    localparam logic [3:0] CMO_BITRAM_HIGH = 4'h2;
    localparam logic [7:0] CMO_INVALID = 8'hFF;

    ////////////////////////////////////////////////////////////////////////////////
    // Hardware register offsets in the internal data space
    localparam logic [7:0] CMO_ADDR_SP = 8'h81;
    localparam logic [7:0] CMO_ADDR_DPL = 8'h82;
    localparam logic [7:0] CMO_ADDR_DPH = 8'h83;
    localparam logic [7:0] CMO_ADDR_PSW = 8'hD0;
    localparam logic [7:0] CMO_ADDR_ACC = 8'hE0;
    localparam logic [7:0] CMO_ADDR_B = 8'hF0;

    ////////////////////////////////////////////////////////////////////////////////
    // Program status word fields and reset values
    localparam int CMO_PSW_CY = 7;
    localparam int CMO_PSW_AC = 6;
    localparam int CMO_PSW_BANK_HI = 4;
    localparam int CMO_PSW_BANK_LO = 3;
    localparam int CMO_PSW_OV = 2;
    localparam int CMO_PSW_P = 0;
    localparam logic [7:0] CMO_SP_RST = 8'h07;
    localparam logic [15:0] CMO_PC_RST = 16'h0000;
    localparam logic [15:0] CMO_DATA_POINTER_RST = 16'h0000;
    localparam logic [7:0] CMO_BYTE_RST = 8'h00;

    ////////////////////////////////////////////////////////////////////////////////
    // Commands, operand modes, states and carriers
    typedef enum logic [4:0] {
        OP_NOP, OP_RD_BYTE, OP_WR_BYTE, OP_ADD, OP_ADD_WITH_CARRY, OP_SUBTRACT_WITH_BORROW, OP_DA, OP_MUL,
        OP_DIV, OP_INC, OP_DEC, OP_AND, OP_OR, OP_XOR, OP_INV, OP_BSET, OP_BCLR,
        OP_BINV, OP_BAND, OP_BOR, OP_BJMP, OP_PUSH, OP_POP, OP_CALL, OP_RET,
        OP_JUMP, OP_FETCH, OP_CTAB, OP_XRD, OP_XWR, OP_DATA_POINTER_LD
    } cmo_op_e;

    typedef enum logic [2:0] {MD_ACC, MD_IMM, MD_DIR, MD_REG, MD_IND} cmo_mode_e;

    typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_ISSUE = 2'b01, ST_COLLECT = 2'b11} cmo_state_e;

    typedef struct packed {
        cmo_op_e op;
        cmo_mode_e mode;
        logic [7:0] addr;
        logic [7:0] imm;
        logic [7:0] bit_addr;
        logic bit_neg;
        logic to_mem;
        logic [15:0] target;
    } cmo_cmd_s;

    typedef struct packed {
        logic [15:0] pc;
        logic [15:0] data_pointer;
        logic [7:0] stack_pointer;
        logic [7:0] acc;
        logic [7:0] b;
        logic [7:0] program_status_word;
    } cmo_view_s;

endpackage : cmo_pkg

//--- cmo_core.sv
// Processor-core memory organisation: internal RAM, register banks, stack,
// hardware registers, bit space, byte/bit arithmetic and code/external paths.
// Assumes the external code and data memories answer one cycle after a strobe.
// Function
// - 4K on-chip code, 60K off-chip extension
// - 128 RAM bytes plus register region
// - external data space up to 64K
// - code, internal, external data distinct paths
// - 16-bit PC, equal fetch time everywhere
// - unmapped register addresses are unusable
// - bytes 20h-2Fh and 8-aligned registers bit addressable
// - all data paths one byte wide
// - bit set, clear, invert, carry logic, jump
// - 16-bit data pointer for long addresses
// - decimal adjust leaves two BCD digits
// - arithmetic results go to accumulator; MUL high byte and DIV remainder go to B
// - multiply and divide are unsigned
// - add-one and subtract-one on any byte
// - and/or on bytes or bits, xor bytes
// - logic results to accumulator/carry or memory
// - four banks of eight registers, 32 bytes
// - bank-select bits pick bank at 8n
// - stack saves PC and pushed data
// - stack pointer pre-increments, resets to 07
// - reset clears PC; RAM left undefined
`timescale 1ns/1ps
module cmo_core
    import cmo_pkg::*;
#(
    parameter int CODE_ONCHIP = CMO_CODE_ONCHIP_BYTES
)(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Command port
    input wire logic cmd_valid,
    input wire cmo_cmd_s cmd,
    output logic cmd_ready,
    output logic rsp_valid,
    output logic [7:0] rsp_data,
    // On-chip code memory load
    input wire logic load_valid,
    input wire logic [11:0] load_addr,
    input wire logic [7:0] load_data,
    // Off-chip code memory
    output logic ext_code_rd,
    output logic [15:0] ext_code_addr,
    input wire logic [7:0] ext_code_data,
    // External data memory
    output logic xdata_rd,
    output logic xdata_wr,
    output logic [15:0] xdata_addr,
    output logic [7:0] xdata_wdata,
    input wire logic [7:0] xdata_rdata,
    // State view
    output cmo_view_s view
);

    ////////////////////////////////////////////////////////////////////////////////
    // Storage
    logic [7:0] ram [CMO_IRAM_BYTES];
    logic [7:0] rom [CODE_ONCHIP];
    logic [7:0] rom_q;
    logic [15:0] pc_q, pc_d, data_pointer_q, data_pointer_d, addr_q, addr_d;
    logic [7:0] sp_q, sp_d, acc_q, acc_d, b_q, b_d, psw_q, psw_d, wdata_q, wdata_d;
    logic [7:0] rsp_data_q, rsp_data_d;
    logic rsp_valid_q, rsp_valid_d;
    cmo_op_e kind_q, kind_d;
    cmo_state_e state_q, state_d;
    logic take;
    logic gw_en, gw_bad, hi_en;
    logic [7:0] gw_addr, gw_data, hi_addr, hi_data;

    assign take = cmd_valid && (state_q == ST_IDLE);
    assign cmd_ready = (state_q == ST_IDLE);
    assign rsp_valid = rsp_valid_q;
    assign rsp_data = rsp_data_q;
    assign view = '{pc_q, data_pointer_q, sp_q, acc_q, b_q, psw_q};

    ////////////////////////////////////////////////////////////////////////////////
    // Reads of the internal data space
    function automatic logic sfr_hit(input logic [7:0] a);
        return a == CMO_ADDR_SP || a == CMO_ADDR_DPL || a == CMO_ADDR_DPH ||
            a == CMO_ADDR_PSW || a == CMO_ADDR_ACC || a == CMO_ADDR_B;
    endfunction : sfr_hit

    function automatic logic [7:0] rd_byte(input logic [7:0] a);
        if (!a[7])
            return ram[a[6:0]];
        case (a)
            CMO_ADDR_SP: return sp_q;
            CMO_ADDR_DPL: return data_pointer_q[7:0];
            CMO_ADDR_DPH: return data_pointer_q[15:8];
            CMO_ADDR_PSW: return psw_q;
            CMO_ADDR_ACC: return acc_q;
            CMO_ADDR_B: return b_q;
            default: return CMO_BYTE_RST; // Unusable hole
        endcase
    endfunction : rd_byte

    ////////////////////////////////////////////////////////////////////////////////
    // Operand location, operand value and bit location
    logic [7:0] reg_addr, ptr_addr, loc, opv, bit_byte, bit_val, spn, sp_top;
    logic loc_bad, bx, cin;
    logic [8:0] sum9, da9;
    logic [4:0] nib5;
    logic [15:0] prod;

    always_comb
    begin
        reg_addr = {3'b000, psw_q[CMO_PSW_BANK_HI:CMO_PSW_BANK_LO],
            cmd.addr[2:0]};
        ptr_addr = rd_byte({3'b000, psw_q[CMO_PSW_BANK_HI:CMO_PSW_BANK_LO], 2'b00, cmd.addr[0]});
        loc_bad = 1'b0;
        case (cmd.mode)
            MD_ACC: loc = CMO_ADDR_ACC;
            MD_DIR: loc = cmd.addr;
            MD_REG: loc = reg_addr;
            MD_IND:
            begin
                loc = ptr_addr;
                loc_bad = ptr_addr[7]; // Indirect reach stops at RAM
            end
            default: loc = cmd.addr;
        endcase
        if (cmd.mode == MD_IMM)
            opv = cmd.imm;
        else if (loc_bad)
            opv = CMO_INVALID;
        else
            opv = rd_byte(loc);
        // Low half bit area sits at 20h-2Fh, high half on 8-aligned registers
        bit_byte = cmd.bit_addr[7] ? {cmd.bit_addr[7:3], 3'b000} :
            {CMO_BITRAM_HIGH, cmd.bit_addr[6:3]};
        bit_val = rd_byte(bit_byte);
        bx = bit_val[cmd.bit_addr[2:0]];
        spn = sp_q + 8'h01;
        sp_top = sp_q[7] ? CMO_INVALID : ram[sp_q[6:0]];
        cin = (cmd.op == OP_ADD) ? 1'b0 : psw_q[CMO_PSW_CY];
        sum9 = {1'b0, acc_q} + {1'b0, opv} + {8'h00, cin};
        nib5 = {1'b0, acc_q[3:0]} + {1'b0, opv[3:0]} + {4'h0, cin};
        prod = acc_q * b_q; // Unsigned operands
        da9 = {1'b0, acc_q};
        if (acc_q[3:0] > 4'h9 || psw_q[CMO_PSW_AC])
            da9 = da9 + 9'h006;
        if (da9[7:4] > 4'h9 || psw_q[CMO_PSW_CY] || da9[8])
            da9 = da9 + 9'h060;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Next-state decode of one command
    logic [8:0] diff9;

    always_comb
    begin
        pc_d = pc_q;
        sp_d = sp_q;
        data_pointer_d = data_pointer_q;
        acc_d = acc_q;
        b_d = b_q;
        psw_d = psw_q;
        addr_d = addr_q;
        wdata_d = wdata_q;
        kind_d = kind_q;
        state_d = state_q;
        rsp_valid_d = 1'b0;
        rsp_data_d = rsp_data_q;
        gw_en = 1'b0;
        gw_bad = loc_bad;
        gw_addr = loc;
        gw_data = opv;
        hi_en = 1'b0;
        hi_addr = sp_q + 8'h02;
        hi_data = pc_q[15:8];
        diff9 = {1'b0, acc_q} - {1'b0, opv} - {8'h00, cin};
        case (state_q)
            ST_IDLE:
            begin
                if (take)
                begin
                    rsp_valid_d = 1'b1;
                    rsp_data_d = opv;
                    case (cmd.op)
                        OP_WR_BYTE:
                        begin
                            gw_en = (cmd.mode != MD_IMM);
                            gw_data = cmd.imm;
                        end
                        OP_ADD, OP_ADD_WITH_CARRY:
                        begin
                            acc_d = sum9[7:0];
                            psw_d[CMO_PSW_CY] = sum9[8];
                            psw_d[CMO_PSW_AC] = nib5[4];
                            psw_d[CMO_PSW_OV] = (acc_q[7] == opv[7]) && (sum9[7] != acc_q[7]);
                        end
                        OP_SUBTRACT_WITH_BORROW:
                        begin
                            acc_d = diff9[7:0];
                            psw_d[CMO_PSW_CY] = diff9[8];
                            psw_d[CMO_PSW_AC] = {1'b0, acc_q[3:0]} <
                                ({1'b0, opv[3:0]} + {4'h0, cin});
                            psw_d[CMO_PSW_OV] = (acc_q[7] != opv[7]) && (diff9[7] != acc_q[7]);
                        end
                        OP_DA:
                        begin
                            acc_d = da9[7:0];
                            psw_d[CMO_PSW_CY] = psw_q[CMO_PSW_CY] | da9[8];
                        end
                        OP_MUL:
                        begin
                            acc_d = prod[7:0];
                            b_d = prod[15:8];
                            psw_d[CMO_PSW_OV] = |prod[15:8];
                            psw_d[CMO_PSW_CY] = 1'b0;
                        end
                        OP_DIV:
                        begin
                            psw_d[CMO_PSW_CY] = 1'b0;
                            psw_d[CMO_PSW_OV] = (b_q == CMO_BYTE_RST);
                            if (b_q != CMO_BYTE_RST)
                            begin
                                acc_d = acc_q / b_q;
                                b_d = acc_q % b_q;
                            end
                        end
                        OP_INC, OP_DEC, OP_INV:
                        begin
                            gw_en = (cmd.mode != MD_IMM);
                            gw_data = (cmd.op == OP_INC) ? opv + 8'h01 :
                                (cmd.op == OP_DEC) ? opv - 8'h01 : ~opv;
                        end
                        OP_AND, OP_OR, OP_XOR:
                        begin
                            gw_data = (cmd.op == OP_AND) ? (acc_q & opv) :
                                (cmd.op == OP_OR) ? (acc_q | opv) : (acc_q ^ opv);
                            gw_en = cmd.to_mem && (cmd.mode != MD_IMM);
                            if (!cmd.to_mem)
                                acc_d = gw_data;
                        end
                        OP_BSET, OP_BCLR, OP_BINV:
                        begin
                            gw_en = 1'b1;
                            gw_bad = 1'b0;
                            gw_addr = bit_byte;
                            gw_data = bit_val;
                            gw_data[cmd.bit_addr[2:0]] = (cmd.op == OP_BSET) ? 1'b1 :
                                (cmd.op == OP_BCLR) ? 1'b0 : ~bx;
                        end
                        OP_BAND:
                            psw_d[CMO_PSW_CY] = psw_q[CMO_PSW_CY] & (bx ^ cmd.bit_neg);
                        OP_BOR: psw_d[CMO_PSW_CY] = psw_q[CMO_PSW_CY] | (bx ^ cmd.bit_neg);
                        OP_BJMP:
                        begin
                            rsp_data_d = {7'b0000000, bx};
                            if (bx ^ cmd.bit_neg)
                                pc_d = cmd.target;
                        end
                        OP_PUSH:
                        begin
                            sp_d = spn; // Increment first, then write
                            gw_en = 1'b1;
                            gw_addr = spn;
                            gw_bad = spn[7];
                        end
                        OP_POP:
                        begin
                            rsp_data_d = sp_top;
                            sp_d = sp_q - 8'h01;
                            gw_en = (cmd.mode != MD_IMM);
                            gw_data = sp_top;
                        end
                        OP_CALL:
                        begin
                            gw_en = 1'b1;
                            gw_addr = spn;
                            gw_bad = spn[7];
                            gw_data = pc_q[7:0];
                            hi_en = !hi_addr[7];
                            sp_d = sp_q + 8'h02;
                            pc_d = cmd.target;
                        end
                        OP_RET:
                        begin
                            pc_d = {sp_top, ram[7'(sp_q - 8'h01)]};
                            sp_d = sp_q - 8'h02;
                        end
                        OP_JUMP: pc_d = cmd.target;
                        OP_DATA_POINTER_LD: data_pointer_d = cmd.target;
                        OP_FETCH, OP_CTAB, OP_XRD, OP_XWR:
                        begin
                            rsp_valid_d = 1'b0;
                            state_d = ST_ISSUE;
                            kind_d = cmd.op;
                            wdata_d = acc_q;
                            addr_d = (cmd.op == OP_FETCH) ? pc_q :
                                (cmd.op == OP_CTAB) ? data_pointer_q + {8'h00, acc_q} : data_pointer_q;
                            if (cmd.op == OP_FETCH)
                                pc_d = pc_q + 16'h0001;
                        end
                        default: rsp_data_d = opv;
                    endcase
                end
            end
            ST_ISSUE: state_d = ST_COLLECT;
            ST_COLLECT:
            begin
                state_d = ST_IDLE;
                rsp_valid_d = 1'b1;
                case (kind_q)
                    OP_FETCH, OP_CTAB:
                    begin
                        rsp_data_d = (addr_q <= CMO_CODE_ONCHIP_TOP) ? rom_q :
                            ext_code_data;
                        if (kind_q == OP_CTAB)
                            acc_d = rsp_data_d;
                    end
                    OP_XRD:
                    begin
                        rsp_data_d = xdata_rdata;
                        acc_d = xdata_rdata;
                    end
                    default: rsp_data_d = wdata_q;
                endcase
            end
            default: state_d = ST_IDLE;
        endcase
        // Byte writes into the hardware register region land on their registers
        if (gw_en && !gw_bad && gw_addr[7])
        begin
            case (gw_addr)
                CMO_ADDR_SP: sp_d = gw_data;
                CMO_ADDR_DPL: data_pointer_d[7:0] = gw_data;
                CMO_ADDR_DPH: data_pointer_d[15:8] = gw_data;
                CMO_ADDR_PSW: psw_d = gw_data;
                CMO_ADDR_ACC: acc_d = gw_data;
                CMO_ADDR_B: b_d = gw_data;
                default: psw_d = psw_d;
            endcase
        end
        psw_d[CMO_PSW_P] = ^acc_d;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            pc_q <= CMO_PC_RST;
            sp_q <= CMO_SP_RST;
            data_pointer_q <= CMO_DATA_POINTER_RST;
            acc_q <= CMO_BYTE_RST;
            b_q <= CMO_BYTE_RST;
            psw_q <= CMO_BYTE_RST;
        end
        else
        begin
            pc_q <= pc_d;
            sp_q <= sp_d;
            data_pointer_q <= data_pointer_d;
            acc_q <= acc_d;
            b_q <= b_d;
            psw_q <= psw_d;
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            state_q <= ST_IDLE;
            kind_q <= OP_NOP;
            addr_q <= CMO_PC_RST;
            wdata_q <= CMO_BYTE_RST;
            rsp_valid_q <= 1'b0;
            rsp_data_q <= CMO_BYTE_RST;
        end
        else
        begin
            state_q <= state_d;
            kind_q <= kind_d;
            addr_q <= addr_d;
            wdata_q <= wdata_d;
            rsp_valid_q <= rsp_valid_d;
            rsp_data_q <= rsp_data_d;
        end
    end

    // Internal RAM keeps no reset value
    always_ff @(posedge clock)
    begin
        if (gw_en && !gw_bad && !gw_addr[7])
            ram[gw_addr[6:0]] <= gw_data;
        if (hi_en)
            ram[hi_addr[6:0]] <= hi_data;
    end

    // On-chip code array, read one cycle after issue like the off-chip path
    always_ff @(posedge clock)
    begin
        if (load_valid)
            rom[load_addr] <= load_data;
        rom_q <= rom[addr_q[11:0]];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // External strobes
    assign ext_code_rd = (state_q == ST_ISSUE) && (kind_q == OP_FETCH || kind_q == OP_CTAB) &&
        (addr_q > CMO_CODE_ONCHIP_TOP);
    assign ext_code_addr = addr_q;
    assign xdata_rd = (state_q == ST_ISSUE) && (kind_q == OP_XRD);
    assign xdata_wr = (state_q == ST_ISSUE) && (kind_q == OP_XWR);
    assign xdata_addr = addr_q;
    assign xdata_wdata = wdata_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    sp_reset_a: assert property (@(posedge clock)
        $past(rst) && !rst |-> sp_q == CMO_SP_RST)
        else $error("stack pointer not 07 after reset");
    pc_reset_a: assert property (@(posedge clock)
        $past(rst) && !rst |-> pc_q == CMO_PC_RST)
        else $error("program counter not zero after reset");
    push_step_a: assert property (@(posedge clock) disable iff (rst)
        take && cmd.op == OP_PUSH && !sp_q[7] && sp_q != 8'h7F && cmd.mode == MD_IMM
        |=> sp_q == $past(sp_q) + 8'h01 && ram[sp_q[6:0]] == $past(cmd.imm))
        else $error("push did not pre-increment and store");
    pop_step_a: assert property (@(posedge clock) disable iff (rst)
        take && cmd.op == OP_POP && cmd.mode == MD_ACC && !sp_q[7]
        |=> sp_q == $past(sp_q) - 8'h01 && acc_q == $past(ram[sp_q[6:0]]))
        else $error("pop did not read top then decrement");
    call_save_a: assert property (@(posedge clock) disable iff (rst)
        take && cmd.op == OP_CALL && sp_q < 8'h7E
        |=> sp_q == $past(sp_q) + 8'h02 && pc_q == $past(cmd.target) &&
            ram[7'(sp_q - 8'h01)] == $past(pc_q[7:0]) && ram[sp_q[6:0]] == $past(pc_q[15:8]))
        else $error("call did not save the program counter");
    bank_map_a: assert property (@(posedge clock) disable iff (rst)
        take && cmd.op == OP_WR_BYTE && cmd.mode == MD_REG
        |=> ram[$past({2'b00, psw_q[CMO_PSW_BANK_HI:CMO_PSW_BANK_LO],
            cmd.addr[2:0]})] == $past(cmd.imm))
        else $error("register write missed bank 8n+k");
    fetch_equal_a: assert property (@(posedge clock) disable iff (rst)
        take && cmd.op == OP_FETCH |=> !rsp_valid ##1 !rsp_valid ##1 rsp_valid && cmd_ready)
        else $error("fetch latency differs from three cycles");
    mul_unsigned_a: assert property (@(posedge clock) disable iff (rst)
        take && cmd.op == OP_MUL |=> {b_q, acc_q} == $past(acc_q) * $past(b_q))
        else $error("unsigned product wrong");
    sfr_hole_a: assert property (@(posedge clock) disable iff (rst)
        take && cmd.op == OP_RD_BYTE && cmd.mode == MD_DIR && cmd.addr[7] && !sfr_hit(cmd.addr)
        |=> rsp_valid && rsp_data == CMO_BYTE_RST)
        else $error("unmapped register address read not zero");
    xdata_path_a: assert property (@(posedge clock) disable iff (rst)
        take && cmd.op == OP_XRD |=> xdata_rd && !ext_code_rd && !xdata_wr ##1 !xdata_rd)
        else $error("external read strobe wrong");

endmodule : cmo_core

//--- cmo_ext_mem.sv
// Far-side model of off-chip code and data memory; assumes the strobes of cmo_core.
`timescale 1ns/1ps
module cmo_ext_mem (
    input wire logic clock,
    input wire logic ext_code_rd,
    input wire logic [15:0] ext_code_addr,
    output logic [7:0] ext_code_data,
    input wire logic xdata_rd,
    input wire logic xdata_wr,
    input wire logic [15:0] xdata_addr,
    input wire logic [7:0] xdata_wdata,
    output logic [7:0] xdata_rdata
);
    logic [7:0] mem_q [256];
    always_ff @(posedge clock)
    begin
        ext_code_data <= ext_code_rd ? ext_code_addr[15:8] ^ ext_code_addr[7:0] : ~ext_code_data;
        xdata_rdata <= xdata_rd ? mem_q[xdata_addr[7:0]] : ~xdata_rdata;
        if (xdata_wr)
            mem_q[xdata_addr[7:0]] <= xdata_wdata;
    end
endmodule : cmo_ext_mem

//--- test_cpu_data_memory_organization.sv
// Testbench of cmo_core; assumes cmo_ext_mem as off-chip code and data memory.
`timescale 1ns/1ps
module test_cpu_data_memory_organization
    import cmo_pkg::*; ;
    logic clock = 1'b0, rst = 1'b1, cmd_valid = 1'b0, load_valid = 1'b1;
    logic cmd_ready, rsp_valid, ext_code_rd, xdata_rd, xdata_wr;
    logic [7:0] load_data = 8'hA7, rsp_data, ext_code_data, xdata_wdata, xdata_rdata;
    logic [11:0] load_addr = 12'h000;
    logic [15:0] ext_code_addr, xdata_addr;
    cmo_cmd_s cmd = '0;
    cmo_view_s view;
    int fail_count = 0, tests_run = 0;
    always #25 clock = ~clock;
    cmo_core i_dut (
        .clock(clock), .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .load_valid(load_valid),
        .load_addr(load_addr), .load_data(load_data), .ext_code_rd(ext_code_rd),
        .ext_code_addr(ext_code_addr), .ext_code_data(ext_code_data), .xdata_rd(xdata_rd),
        .xdata_wr(xdata_wr), .xdata_addr(xdata_addr), .xdata_wdata(xdata_wdata),
        .xdata_rdata(xdata_rdata), .view(view)
    );
    cmo_ext_mem i_mem (
        .clock(clock), .ext_code_rd(ext_code_rd), .ext_code_addr(ext_code_addr),
        .ext_code_data(ext_code_data), .xdata_rd(xdata_rd), .xdata_wr(xdata_wr),
        .xdata_addr(xdata_addr), .xdata_wdata(xdata_wdata), .xdata_rdata(xdata_rdata)
    );
    task automatic check(input logic [23:0] seen, want);
        tests_run++;
        if (seen !== want)
            $display("ERROR %0t: saw %h, want %h", $time, seen, want);
        fail_count += int'(seen !== want);
    endtask : check
    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict
    task automatic run(input cmo_op_e op, input logic [7:0] a = 8'h00, v = 8'h00,
        input cmo_mode_e md = MD_DIR);
        int n;
        @(negedge clock);
        cmd = {op, md, a, v, a, 1'b0, 1'b0, a, v};
        cmd_valid = 1'b1;
        @(negedge clock);
        cmd_valid = 1'b0;
        for (n = 0; n < 9 && rsp_valid !== 1'b1; n++)
            @(negedge clock);
        check(24'(n), (op inside {OP_FETCH, OP_CTAB, OP_XRD, OP_XWR}) ? 24'h2 : 24'h0);
        if (n > 8)
            give_verdict();
    endtask : run
    task automatic t_space();
        run(OP_FETCH);
        check({rsp_data, view.pc}, {8'hA7, 16'h0001});
        run(OP_JUMP, 8'h20);
        run(OP_FETCH);
        check({rsp_data, view.pc}, {8'h20, 16'h2001});
        run(OP_DATA_POINTER_LD, 8'h12, 8'h34);
        run(OP_WR_BYTE, 8'hE0, 8'hA5);
        run(OP_XWR);
        run(OP_WR_BYTE, 8'hE0, 8'h00);
        run(OP_XRD);
        check({xdata_addr, view.acc}, {16'h1234, 8'hA5});
        run(OP_WR_BYTE, 8'h20, 8'h00);
        run(OP_BSET, 8'h07);
        run(OP_RD_BYTE, 8'h20);
        check(rsp_data, 8'h80);
        run(OP_RD_BYTE, 8'h85);
        check(rsp_data, 8'h00);
        $display("address space test done");
    endtask : t_space
    task automatic t_internal();
        run(OP_WR_BYTE, 8'hE0, 8'h5A);
        run(OP_PUSH, 8'hE0);
        run(OP_WR_BYTE, 8'hD0, 8'h08);
        run(OP_RD_BYTE, 8'h00, 8'h00, MD_REG);
        check({view.stack_pointer, rsp_data}, {8'h08, 8'h5A});
        run(OP_POP, 8'h30);
        check({view.stack_pointer, rsp_data}, {8'h07, 8'h5A});
        run(OP_PUSH, 8'h00, 8'hC3, MD_IMM);
        run(OP_POP, 8'h00, 8'h00, MD_ACC);
        check({view.stack_pointer, view.acc}, {8'h07, 8'hC3});
        run(OP_WR_BYTE, 8'h81, 8'h5F);
        run(OP_JUMP, 8'h12, 8'h34);
        run(OP_CALL, 8'h20, 8'h00);
        check({view.pc, view.stack_pointer}, {16'h2000, 8'h61});
        run(OP_RET);
        check({view.pc, view.stack_pointer}, {16'h1234, 8'h5F});
        run(OP_WR_BYTE, 8'hE0, 8'h19);
        run(OP_ADD, 8'h00, 8'h28, MD_IMM);
        run(OP_DA);
        check(view.acc, 8'h47);
        run(OP_WR_BYTE, 8'hE0, 8'hC8);
        run(OP_WR_BYTE, 8'hF0, 8'h03);
        run(OP_MUL);
        check({view.b, view.acc}, {8'h02, 8'h58});
        run(OP_WR_BYTE, 8'hE0, 8'hC8);
        run(OP_WR_BYTE, 8'hF0, 8'h03);
        run(OP_DIV);
        check({view.b, view.acc}, {8'h02, 8'h42});
        $display("stack and arithmetic test done");
    endtask : t_internal
    task automatic t_logic();
        run(OP_WR_BYTE, 8'hE0, 8'h0F);
        run(OP_AND, 8'h00, 8'h3C, MD_IMM);
        run(OP_OR, 8'h00, 8'h40, MD_IMM);
        run(OP_XOR, 8'h00, 8'hFF, MD_IMM);
        check(view.acc, 8'hB3);
        run(OP_INC, 8'hE0);
        run(OP_INV, 8'hE0);
        check(view.acc, 8'h4B);
        run(OP_WR_BYTE, 8'h40, 8'h00);
        run(OP_WR_BYTE, 8'h01, 8'h40, MD_REG);
        run(OP_DEC, 8'h01, 8'h00, MD_IND);
        run(OP_RD_BYTE, 8'h40);
        check(rsp_data, 8'hFF);
        run(OP_BSET, 8'hD7);
        run(OP_BCLR, 8'h07);
        run(OP_BAND, 8'h07);
        run(OP_BINV, 8'h00);
        run(OP_BOR, 8'h00);
        run(OP_BJMP, 8'hD7, 8'h55);
        check({view.pc, rsp_data}, {16'hD755, 8'h01});
        run(OP_RD_BYTE, 8'h20);
        check(rsp_data, 8'h01);
        run(OP_WR_BYTE, 8'hE0, 8'h10);
        run(OP_ADD_WITH_CARRY, 8'h00, 8'h05, MD_IMM);
        run(OP_SUBTRACT_WITH_BORROW, 8'h00, 8'h20, MD_IMM);
        check({view.acc, view.program_status_word[CMO_PSW_CY]}, {8'hF6, 1'b1});
        run(OP_DATA_POINTER_LD);
        run(OP_WR_BYTE, 8'hE0, 8'h00);
        run(OP_CTAB);
        check(view.acc, 8'hA7);
        $display("logic and bit test done");
    endtask : t_logic
    initial
    begin
        repeat (10) @(negedge clock);
        rst = 1'b0;
        load_valid = 1'b0;
        t_space();
        t_internal();
        t_logic();
        give_verdict();
    end
endmodule : test_cpu_data_memory_organization
